// File: src/bsr_pkg.sv
// Package of constants for the bipolar supply setpoint block.
package bsr_pkg;
    localparam int BSR_SET_W = 16;
    localparam int BSR_AVG_N = 16;
    localparam int BSR_AVG_LOG2 = 4;
    localparam int BSR_CLK_HZ = 50_000_000;
    localparam int BSR_VALID_MS = 320;
    localparam int BSR_VALID_CYC = BSR_VALID_MS * (BSR_CLK_HZ / 1000);
    localparam int BSR_SETTLE_CYC = 1000;
    localparam logic [15:0] BSR_SET_RST = 16'h0000;
    localparam logic [15:0] BSR_MAG_MAX = 16'h7fff;
    localparam logic [15:0] BSR_NEG_MAX = 16'h8001;
endpackage : bsr_pkg

// File: src/bsr_avg.sv
// Running average of the last sixteen signed measurement samples.
`timescale 1ns/100ps
`default_nettype none
module bsr_avg
    import bsr_pkg::*;
#(
    parameter int W = BSR_SET_W
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic clr_in,
    input wire logic smp_vld_in,
    input wire logic [W-1:0] smp_in,
    output logic [W-1:0] avg_out,
    output logic full_out
);
    localparam int SW = W + BSR_AVG_LOG2;
    typedef struct packed {
        logic [BSR_AVG_N-1:0][W-1:0] win;
        logic [SW-1:0] sum;
        logic [BSR_AVG_LOG2:0] cnt;
        logic [W-1:0] avg;
    } bsr_avg_st_t;
    bsr_avg_st_t s_q, s_d;

    function automatic logic [SW-1:0] sext(input logic [W-1:0] v);
        sext = {{BSR_AVG_LOG2{v[W-1]}}, v};
    endfunction

    always_comb begin
        s_d = s_q;
        if (clr_in) begin
            s_d = '0;
        end else if (smp_vld_in) begin
            // Window sum: add newest, drop oldest; stays exact with no drift.
            s_d.sum = s_q.sum + sext(smp_in) - sext(s_q.win[BSR_AVG_N-1]);
            s_d.win = {s_q.win[BSR_AVG_N-2:0], smp_in};
            if (s_q.cnt != BSR_AVG_N[BSR_AVG_LOG2:0]) begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
            s_d.avg = s_d.sum[SW-1:BSR_AVG_LOG2];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign avg_out = s_q.avg;
    assign full_out = (s_q.cnt == BSR_AVG_N[BSR_AVG_LOG2:0]);
endmodule : bsr_avg
`default_nettype wire

// File: src/bsr_top.sv
// Setpoint hold, analog drive and averaged readback control for the card.
// Functional notes
// - Start in local mode; front panel controls.
// - Reset zeroes voltage, current; output off.
// - Setpoints are signed 16-bit, 15-bit magnitude.
// - Accepted setpoint updates analog control output in remote with output on.
// - Readback averages the last sixteen samples.
// - Readback valid after settle plus 320 ms.
// - Enabled card overrides the analog control path.
`timescale 1ns/100ps
`default_nettype none
module bsr_top
    import bsr_pkg::*;
#(
    parameter int W = BSR_SET_W,
    parameter int SETTLE_CYC = BSR_SETTLE_CYC,
    parameter int VALID_CYC = BSR_VALID_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic card_en_in,
    input wire logic remote_req_in,
    input wire logic local_req_in,
    input wire logic volt_wr_in,
    input wire logic curr_wr_in,
    input wire logic [W-1:0] set_in,
    input wire logic out_on_wr_in,
    input wire logic out_on_in,
    input wire logic [W-1:0] panel_volt_in,
    input wire logic [W-1:0] panel_curr_in,
    input wire logic [W-1:0] analog_volt_in,
    input wire logic [W-1:0] analog_curr_in,
    input wire logic meas_sel_curr_in,
    input wire logic meas_vld_in,
    input wire logic [W-1:0] meas_in,
    output logic remote_out,
    output logic out_on_out,
    output logic [W-1:0] volt_drive_out,
    output logic [W-1:0] curr_drive_out,
    output logic [W-1:0] readback_out,
    output logic readback_vld_out,
    output logic analog_path_off_out
);
    typedef enum logic [1:0] {
        BSR_IDLE,
        BSR_SETTLE,
        BSR_WAIT,
        BSR_VALID
    } bsr_rb_t;

    // One register holds all top-level state and the averager shares ce_in, so ce_in low freezes both.
    typedef struct packed {
        logic remote;
        logic out_on;
        logic [W-1:0] volt_set;
        logic [W-1:0] curr_set;
        logic [W-1:0] volt_drv;
        logic [W-1:0] curr_drv;
        logic meas_curr;
        bsr_rb_t rb;
        logic [31:0] tmr;
        logic [W-1:0] rb_val;
        logic rb_vld;
        logic path_off;
    } bsr_st_t;

    bsr_st_t s_q, s_d;
    logic [W-1:0] avg;
    logic avg_full;
    logic avg_clr;

    // Clamp to the 15-bit magnitude range; the lone most-negative code
    // has no positive twin, so it is pulled to the symmetric limit.
    function automatic logic [W-1:0] clamp_mag(input logic [W-1:0] v);
        if (v == {1'b1, {(W-1){1'b0}}}) begin
            clamp_mag = {1'b1, {(W-2){1'b0}}, 1'b1};
        end else begin
            clamp_mag = v;
        end
    endfunction

    // Any host write restarts the readback settling sequence.
    function automatic logic host_write(input logic v_wr, input logic c_wr,
            input logic o_wr);
        host_write = v_wr || c_wr || o_wr;
    endfunction

    // Timer step that saturates, so a stalled average cannot wrap it.
    function automatic logic [31:0] tmr_step(input logic [31:0] t);
        if (t == 32'hffff_ffff) begin
            tmr_step = t;
        end else begin
            tmr_step = t + 32'h0000_0001;
        end
    endfunction

    // The averager is emptied on the cycle in which settling starts.
    assign avg_clr = (s_q.rb == BSR_IDLE) && (s_d.rb == BSR_SETTLE);

    // Only samples taken after the latest restart enter the window.
    bsr_avg #(
        .W(W)
    ) u_avg (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .clr_in(avg_clr),
        .smp_vld_in(meas_vld_in),
        .smp_in(meas_in),
        .avg_out(avg),
        .full_out(avg_full)
    );

    always_comb begin
        s_d = s_q;
        // The flag follows the enable one cycle late, like every output.
        s_d.path_off = card_en_in;
        // Remote needs the card enabled; a disabled card falls to local.
        if (remote_req_in && card_en_in) begin
            s_d.remote = 1'b1;
        end else if (local_req_in || !card_en_in) begin
            s_d.remote = 1'b0;
        end
        if (volt_wr_in) begin
            s_d.volt_set = clamp_mag(set_in);
        end
        if (curr_wr_in) begin
            s_d.curr_set = clamp_mag(set_in);
        end
        if (out_on_wr_in) begin
            s_d.out_on = out_on_in;
        end
        // Drive selection; an enabled card never passes the analog inputs.
        if (!card_en_in) begin
            s_d.volt_drv = analog_volt_in;
            s_d.curr_drv = analog_curr_in;
        end else if (!s_d.remote) begin
            s_d.volt_drv = panel_volt_in;
            s_d.curr_drv = panel_curr_in;
        end else if (s_d.out_on) begin
            s_d.volt_drv = s_d.volt_set;
            s_d.curr_drv = s_d.curr_set;
        end else begin
            // Remote with the output off holds both drives at zero.
            s_d.volt_drv = BSR_SET_RST;
            s_d.curr_drv = BSR_SET_RST;
        end
        // A new setpoint or a new measured quantity restarts settling.
        if (host_write(volt_wr_in, curr_wr_in, out_on_wr_in) ||
                meas_sel_curr_in != s_q.meas_curr) begin
            s_d.rb = BSR_IDLE;
            s_d.meas_curr = meas_sel_curr_in;
        end
        // Validity runs settle, then the full interval, then valid.
        case (s_q.rb)
            BSR_IDLE: begin
                if (s_d.rb == BSR_IDLE && !host_write(volt_wr_in,
                        curr_wr_in, out_on_wr_in)) begin
                    s_d.rb = BSR_SETTLE;
                end
                s_d.tmr = '0;
                s_d.rb_vld = 1'b0;
            end
            BSR_SETTLE: begin
                if (s_d.rb != BSR_IDLE) begin
                    s_d.tmr = tmr_step(s_q.tmr);
                    if (s_q.tmr >= 32'(SETTLE_CYC - 1)) begin
                        s_d.rb = BSR_WAIT;
                        s_d.tmr = '0;
                    end
                end
            end
            BSR_WAIT: begin
                if (s_d.rb != BSR_IDLE) begin
                    s_d.tmr = tmr_step(s_q.tmr);
                    // A full window of post-restart samples is needed too.
                    if (s_q.tmr >= 32'(VALID_CYC - 1) && avg_full) begin
                        s_d.rb = BSR_VALID;
                    end
                end
            end
            BSR_VALID: begin
                if (s_d.rb != BSR_IDLE) begin
                    // While valid the readback tracks every new sample.
                    s_d.rb_val = avg;
                    s_d.rb_vld = 1'b1;
                end
            end
            default: begin
                s_d.rb = BSR_IDLE;
            end
        endcase
        // Any exit from the valid state drops the flag in the same cycle.
        if (s_d.rb != BSR_VALID) begin
            s_d.rb_vld = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        // Reset wins over the clock enable, so power-up always zeroes.
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.volt_set <= BSR_SET_RST;
            s_q.curr_set <= BSR_SET_RST;
            s_q.rb <= BSR_IDLE;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the state register.
    assign remote_out = s_q.remote;
    assign out_on_out = s_q.out_on;
    assign volt_drive_out = s_q.volt_drv;
    assign curr_drive_out = s_q.curr_drv;
    assign readback_out = s_q.rb_val;
    assign readback_vld_out = s_q.rb_vld;
    assign analog_path_off_out = s_q.path_off;
endmodule : bsr_top
`default_nettype wire

// File: test/bsr_top_monitor.sv
// Port checker for the setpoint, drive and readback block.
`timescale 1ns/100ps
`default_nettype none
module bsr_top_monitor
    import bsr_pkg::*;
#(
    parameter int SETTLE_CYC = BSR_SETTLE_CYC,
    parameter int VALID_CYC = BSR_VALID_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic card_en_in,
    input wire logic remote_req_in,
    input wire logic local_req_in,
    input wire logic volt_wr_in,
    input wire logic curr_wr_in,
    input wire logic [15:0] set_in,
    input wire logic out_on_wr_in,
    input wire logic [15:0] analog_volt_in,
    input wire logic remote_out,
    input wire logic out_on_out,
    input wire logic [15:0] volt_drive_out,
    input wire logic [15:0] curr_drive_out,
    input wire logic readback_vld_out,
    input wire logic analog_path_off_out
);
    localparam int unsigned LIM = SETTLE_CYC + VALID_CYC;
    int unsigned cnt_q;
    logic live;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Only setpoint writes restart the count, so extra restarts stay legal.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || (ce_in && (volt_wr_in || curr_wr_in))) begin
            cnt_q <= 0;
        end else if (ce_in && cnt_q < LIM) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign live = ce_in && card_en_in && analog_path_off_out &&
        !local_req_in && !out_on_wr_in && remote_out;
    reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |=>
        !remote_out && !out_on_out && volt_drive_out == 16'h0000 &&
        curr_drive_out == 16'h0000) else $error("reset left outputs set");
    stay_local_a: assert property (!remote_out && !remote_req_in |=>
        !remote_out) else $error("remote entered without request");
    card_off_a: assert property (ce_in && !card_en_in &&
        !analog_path_off_out |=> !remote_out &&
        volt_drive_out == $past(analog_volt_in))
        else $error("analog path not passed");
    path_off_a: assert property (rst_n_in && ce_in |=>
        analog_path_off_out == $past(card_en_in)) else $error("path flag");
    volt_set_a: assert property (live && out_on_out && volt_wr_in |=>
        volt_drive_out == ($past(set_in) == 16'h8000 ? BSR_NEG_MAX :
        $past(set_in))) else $error("voltage drive wrong");
    curr_set_a: assert property (live && out_on_out && curr_wr_in |=>
        curr_drive_out == ($past(set_in) == 16'h8000 ? BSR_NEG_MAX :
        $past(set_in))) else $error("current drive wrong");
    out_off_a: assert property (live && !out_on_out |=>
        volt_drive_out == 16'h0000 && curr_drive_out == 16'h0000)
        else $error("drive with output off");
    vld_wait_a: assert property (readback_vld_out |->
        cnt_q >= LIM) else $error("readback valid early");
    ce_hold_a: assert property (!ce_in |=> $stable(volt_drive_out) &&
        $stable(curr_drive_out) && $stable(remote_out) &&
        $stable(out_on_out)) else $error("state moved while frozen");
    cover property (live && out_on_out && volt_wr_in);
    cover property (!ce_in && volt_wr_in);
    cover property ($rose(readback_vld_out));
    cover property (!card_en_in && remote_req_in);
endmodule // bsr_top_monitor
`default_nettype wire

// File: test/bsr_meas_src.sv
// Measurement sample source feeding the readback averager.
`timescale 1ns/100ps
`default_nettype none
module bsr_meas_src (
    input wire logic clk_sys_in,
    input wire logic go_in,
    output logic meas_vld_out,
    output logic [15:0] meas_out
);
    logic [15:0] hist [$];
    logic g;
    initial begin
        meas_vld_out = 1'b0;
        meas_out = 16'h0000;
    end
    // Between samples the line toggles, so a stale value is never reused.
    always @(posedge clk_sys_in) begin
        g = go_in;
        #1;
        if (g && !meas_vld_out) begin
            meas_out = 16'(hist.size()) * 16'h2f1d + 16'h9a03;
            hist.push_back(meas_out);
            meas_vld_out = 1'b1;
        end else begin
            meas_vld_out = 1'b0;
            meas_out = ~meas_out;
        end
    end
endmodule // bsr_meas_src
`default_nettype wire

// File: test/bsr_top_tb.sv
// Self-checking bench for the setpoint, drive and readback block.
`timescale 1ns/100ps
`default_nettype none
module bsr_top_tb;
    import bsr_pkg::*;
    logic clk_sys_in, rst_n_in, ce_in, card_en_in, remote_req_in, go;
    logic local_req_in, volt_wr_in, curr_wr_in, out_on_wr_in, out_on_in;
    logic meas_sel_curr_in, meas_vld_in, remote_out, out_on_out;
    logic readback_vld_out, analog_path_off_out;
    logic [15:0] set_in, panel_volt_in, panel_curr_in, analog_volt_in;
    logic [15:0] analog_curr_in, meas_in, volt_drive_out, curr_drive_out;
    logic [15:0] readback_out, vexp, cexp;
    logic [15:0] corner [4] = '{16'h7fff, 16'h8000, 16'h8001, 16'hffff};
    integer seed = 32'h80e1_becf;
    int miscompares = 0;
    int checks_done = 0;
    bsr_top #(.SETTLE_CYC(5), .VALID_CYC(20)) dut (.*);
    bsr_meas_src src (.clk_sys_in(clk_sys_in), .go_in(go),
        .meas_vld_out(meas_vld_in), .meas_out(meas_in));
    task automatic chk(input logic [15:0] seen, input logic [15:0] expd);
        checks_done++;
        if (seen !== expd) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                expd);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wait_valid;
        go = 1'b1;
        for (int i = 0; i < 200 && readback_vld_out !== 1'b1; i++) step(1);
        go = 1'b0;
        step(4);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [15:0] exp_set(input logic [15:0] v);
        return (v == 16'h8000) ? BSR_NEG_MAX : v;
    endfunction
    function automatic logic [15:0] exp_avg();
        logic signed [19:0] s = 0;
        for (int i = 1; i <= 16; i++) begin
            s += signed'(src.hist[src.hist.size() - i]);
        end
        return s[19:4];
    endfunction
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #100us;
        miscompares++;
        give_verdict();
    end
    initial begin
        {rst_n_in, card_en_in, remote_req_in, local_req_in, go} = '0;
        {volt_wr_in, curr_wr_in, out_on_wr_in, out_on_in} = '0;
        {meas_sel_curr_in, set_in, vexp, cexp} = '0;
        ce_in = 1'b1;
        panel_volt_in = 16'($random(seed));
        panel_curr_in = 16'($random(seed));
        analog_volt_in = 16'($random(seed));
        analog_curr_in = 16'($random(seed));
        step(12);
        chk({volt_drive_out | curr_drive_out}, 16'h0000);
        chk({14'h0000, remote_out, out_on_out}, 16'h0000);
        rst_n_in = 1'b1;
        remote_req_in = 1'b1;
        step(3);
        chk({15'h0000, remote_out}, 16'h0000);
        chk(volt_drive_out, analog_volt_in);
        chk(curr_drive_out, analog_curr_in);
        card_en_in = 1'b1;
        remote_req_in = 1'b0;
        volt_wr_in = 1'b1;
        set_in = 16'h1234;
        step(1);
        volt_wr_in = 1'b0;
        panel_volt_in = 16'($random(seed));
        step(2);
        chk(volt_drive_out, panel_volt_in);
        chk(curr_drive_out, panel_curr_in);
        chk({15'h0000, analog_path_off_out}, 16'h0001);
        remote_req_in = 1'b1;
        step(1);
        remote_req_in = 1'b0;
        chk({15'h0000, remote_out}, 16'h0001);
        chk(volt_drive_out, 16'h0000);
        {out_on_wr_in, out_on_in} = 2'b11;
        step(1);
        out_on_wr_in = 1'b0;
        step(1);
        chk(volt_drive_out, 16'h1234);
        for (int i = 0; i < 10; i++) begin
            set_in = (i < 4) ? corner[i] : 16'($random(seed));
            volt_wr_in = (i != 2);
            curr_wr_in = (i >= 2);
            if (volt_wr_in) vexp = exp_set(set_in);
            if (curr_wr_in) cexp = exp_set(set_in);
            step(1);
            chk(volt_drive_out, vexp);
            chk(curr_drive_out, cexp);
        end
        ce_in = 1'b0;
        set_in = 16'($random(seed));
        step(2);
        chk(volt_drive_out, vexp);
        chk(curr_drive_out, cexp);
        {ce_in, volt_wr_in, curr_wr_in, out_on_wr_in, out_on_in} = 5'b10010;
        step(1);
        out_on_wr_in = 1'b0;
        step(2);
        chk(volt_drive_out | curr_drive_out, 16'h0000);
        wait_valid();
        chk({15'h0000, readback_vld_out}, 16'h0001);
        chk(readback_out, exp_avg());
        volt_wr_in = 1'b1;
        step(1);
        volt_wr_in = 1'b0;
        step(3);
        chk({15'h0000, readback_vld_out}, 16'h0000);
        wait_valid();
        chk({15'h0000, readback_vld_out}, 16'h0001);
        chk(readback_out, exp_avg());
        meas_sel_curr_in = 1'b1;
        step(1);
        chk({15'h0000, readback_vld_out}, 16'h0000);
        local_req_in = 1'b1;
        step(1);
        local_req_in = 1'b0;
        step(2);
        chk(volt_drive_out, panel_volt_in);
        rst_n_in = 1'b0;
        step(2);
        chk({15'h0000, out_on_out}, 16'h0000);
        give_verdict();
    end
endmodule // bsr_top_tb
bind bsr_top bsr_top_monitor #(.SETTLE_CYC(SETTLE_CYC),
    .VALID_CYC(VALID_CYC)) mon (.*);
`default_nettype wire
